// ### hw/sbm_master.sv
// system bus master: ownership, address/data phases, qualifiers
// assumes slaves answer with wait and last on the same clock
`default_nettype none

module sbm_master (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// ownership handshake
	input  wire logic        ownership_request_in,
	output logic             ownership_grant_out,
	// mode inputs
	input  wire logic        misalign_enable_mode,
	input  wire logic [1:0]  bus_width_sel,
	// request from the core
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [27:0] req_addr,
	input  wire logic        req_write,
	input  wire logic [1:0]  req_size,
	input  wire logic [2:0]  req_ctype,
	input  wire logic [2:0]  req_seq,
	input  wire logic        req_addr_only,
	input  wire logic        req_lock,
	input  wire logic        req_periph,
	input  wire logic [31:0] req_wdata,
	// answer to the core
	output logic             rsp_valid,
	output logic             rsp_last,
	output logic [31:0]      rsp_rdata,
	// master-driven bus pins
	output logic [27:0]      sys_address_bus_out,
	output logic [1:0]       transfer_type_out,
	output logic             transfer_start_n_out,
	output logic [3:0]       byte_lane_enable_n_out,
	output logic [1:0]       transfer_size_out,
	output logic             write_not_read_out,
	output logic             ownership_lock_out,
	output logic [2:0]       cycle_status_out,
	output logic [2:0]       sequential_status_out,
	output logic             qualifier_oe_n,
	// data bus pins
	input  wire logic [31:0] sys_data_bus_in,
	output logic [31:0]      sys_data_bus_out,
	output logic             sys_data_bus_oe_n,
	// slave responses
	input  wire logic        wait_response,
	input  wire logic        last_response
);

	sbm_pkg::sbm_state_type state_ff;
	logic [7:0]  beat_ff;
	logic [7:0]  beats_ff;
	logic [27:0] addr_ff;
	logic [1:0]  bsize_ff;
	logic        burst_ff;
	logic        write_ff;
	logic        aonly_ff;
	logic [2:0]  ctype_ff;
	logic [2:0]  seqc_ff;
	logic        lock_ff;
	logic        grant_ff;
	logic        last_seen_ff;
	logic [31:0] wdata_ff;

	logic        idle, accept, beat_end, final_beat, launch;
	logic        req_burst, req_split, l_burst, l_aonly;
	logic [1:0]  size_ok, eff_width, acc_bsize, l_tt;
	logic [2:0]  acc_ctype, l_seq;
	logic [7:0]  acc_beats, l_idx, l_beats;
	logic [27:0] l_addr;

	sbm_lane_if lane_bus ();

	sbm_lane_calc u_lane (
		.lane (lane_bus)
	);

	assign idle       = (state_ff == sbm_pkg::SBM_IDLE);
	assign beat_end   = (state_ff == sbm_pkg::SBM_DATA) && !wait_response;
	assign final_beat = (beat_ff == beats_ff - 8'h01);
	// external master takes priority while the bus is free and unlocked
	assign req_ready  = idle && !grant_ff
		&& !(ownership_request_in && !lock_ff);
	assign accept     = req_valid && req_ready;
	assign launch     = accept || (beat_end && !final_beat);

	// request decode
	always_comb begin
		size_ok = (req_size == sbm_pkg::SBM_SZ_RSVD) ?
			sbm_pkg::SBM_SZ_WORD : req_size;
		if (req_periph)
			eff_width = sbm_pkg::SBM_SZ_HALF;
		else if (bus_width_sel == sbm_pkg::SBM_SZ_RSVD)
			eff_width = sbm_pkg::SBM_SZ_WORD;
		else
			eff_width = bus_width_sel;
		req_burst = (req_seq >= sbm_pkg::SBM_SEQ_BURST_MIN);
		req_split = !req_burst && !req_addr_only
			&& (size_ok > eff_width);
		if (req_burst)
			acc_bsize = sbm_pkg::SBM_SZ_WORD;
		else if (req_split)
			acc_bsize = eff_width;
		else
			acc_bsize = size_ok;
		if (req_burst)
			acc_beats = sbm_pkg::SBM_BURST_BASE
				<< (req_seq - sbm_pkg::SBM_SEQ_BURST_MIN);
		else
			acc_beats = {5'h00, lane_bus.split_beats};
		// misalign codes (while misalign mode is off) and reserved codes fall back to a data access
		if ((req_ctype == sbm_pkg::SBM_CT_MISALIGN && !misalign_enable_mode)
			|| req_ctype == sbm_pkg::SBM_CT_RSVD)
			acc_ctype = sbm_pkg::SBM_CT_DATA;
		else
			acc_ctype = req_ctype;
	end

	// values of the beat being launched
	always_comb begin
		l_addr  = idle ? req_addr : addr_ff + (28'h0000001 << bsize_ff);
		l_idx   = idle ? 8'h00 : beat_ff + 8'h01;
		l_beats = idle ? acc_beats : beats_ff;
		l_burst = idle ? req_burst : burst_ff;
		l_aonly = idle ? req_addr_only : aonly_ff;
		if (l_idx == l_beats - 8'h01)
			l_seq = sbm_pkg::SBM_SEQ_SINGLE;
		else if (l_idx == 8'h00 && l_burst)
			l_seq = idle ? req_seq : seqc_ff;
		else
			l_seq = sbm_pkg::SBM_SEQ_CONT;
		if (l_aonly)
			l_tt = sbm_pkg::SBM_TT_ADDR_ONLY;
		else if (idle || last_seen_ff || last_response)
			l_tt = sbm_pkg::SBM_TT_NONSEQ;
		else
			l_tt = sbm_pkg::SBM_TT_SEQ;
	end

	assign lane_bus.addr_lo   = l_addr[1:0];
	assign lane_bus.beat_size = idle ? acc_bsize : bsize_ff;
	assign lane_bus.req_size  = req_split ? size_ok : eff_width;
	assign lane_bus.width     = eff_width;

	// beat sequencing: one address cycle, then data until no wait
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= sbm_pkg::SBM_IDLE;
		end else begin
			unique case (state_ff)
				sbm_pkg::SBM_IDLE: if (accept) state_ff <= sbm_pkg::SBM_ADDR;
				sbm_pkg::SBM_ADDR: state_ff <= sbm_pkg::SBM_DATA;
				sbm_pkg::SBM_DATA: begin
					if (beat_end)
						state_ff <= final_beat ?
							sbm_pkg::SBM_IDLE : sbm_pkg::SBM_ADDR;
				end
				default: state_ff <= sbm_pkg::SBM_IDLE;
			endcase
		end
	end

	// per-transfer context
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			beat_ff  <= 8'h00;
			beats_ff <= 8'h01;
			addr_ff  <= sbm_pkg::SBM_ADDR_RST;
			bsize_ff <= sbm_pkg::SBM_SZ_BYTE;
			burst_ff <= 1'b0;
			write_ff <= 1'b0;
			aonly_ff <= 1'b0;
			ctype_ff <= sbm_pkg::SBM_CT_OPFETCH;
			seqc_ff  <= sbm_pkg::SBM_SEQ_SINGLE;
		end else if (launch) begin
			beat_ff <= l_idx;
			addr_ff <= l_addr;
			if (accept) begin
				beats_ff <= acc_beats;
				bsize_ff <= acc_bsize;
				burst_ff <= req_burst;
				write_ff <= req_write;
				aonly_ff <= req_addr_only;
				ctype_ff <= acc_ctype;
				seqc_ff  <= req_seq;
			end
		end
	end

	// a last response anywhere in the beat counts for the next launch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			last_seen_ff <= 1'b0;
		else if (launch)
			last_seen_ff <= 1'b0;
		else if (!idle && last_response)
			last_seen_ff <= 1'b1;
	end

	// ownership: lock holds until the core's next accepted transfer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lock_ff  <= 1'b0;
			grant_ff <= 1'b0;
		end else begin
			if (accept)
				lock_ff <= req_lock;
			if (grant_ff)
				grant_ff <= ownership_request_in;
			else if (idle && !lock_ff && ownership_request_in)
				grant_ff <= 1'b1;
		end
	end

	assign ownership_grant_out = grant_ff;
	assign ownership_lock_out  = lock_ff;
	assign qualifier_oe_n      = grant_ff;

	// qualifier pins except the start strobe load on each launch, stable over the whole cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sys_address_bus_out    <= sbm_pkg::SBM_ADDR_RST;
			transfer_type_out      <= sbm_pkg::SBM_TT_ADDR_ONLY;
			transfer_start_n_out   <= 1'b1;
			byte_lane_enable_n_out <= sbm_pkg::SBM_BEN_N_RST;
			transfer_size_out      <= sbm_pkg::SBM_SZ_BYTE;
			write_not_read_out     <= 1'b0;
			cycle_status_out       <= sbm_pkg::SBM_CT_OPFETCH;
			sequential_status_out  <= sbm_pkg::SBM_SEQ_SINGLE;
		end else begin
			transfer_start_n_out <= !launch;
			if (launch) begin
				sys_address_bus_out    <= l_addr;
				transfer_type_out      <= l_tt;
				byte_lane_enable_n_out <= lane_bus.ben_n;
				transfer_size_out      <= lane_bus.beat_size;
				write_not_read_out     <= idle ? req_write : write_ff;
				cycle_status_out       <= idle ? acc_ctype : ctype_ff;
				sequential_status_out  <= l_seq;
			end
		end
	end

	// write data: word kept in lane position; bursts take a new word
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wdata_ff          <= sbm_pkg::SBM_DATA_RST;
			sys_data_bus_oe_n <= 1'b1;
		end else begin
			if (accept || (launch && burst_ff))
				wdata_ff <= req_wdata;
			if (launch)
				sys_data_bus_oe_n <= !((idle ? req_write : write_ff)
					&& !l_aonly);
			else if (beat_end)
				sys_data_bus_oe_n <= 1'b1;
		end
	end

	assign sys_data_bus_out = wdata_ff;

	// per-beat answer to the core
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
			rsp_last  <= 1'b0;
			rsp_rdata <= sbm_pkg::SBM_DATA_RST;
		end else begin
			rsp_valid <= beat_end;
			rsp_last  <= beat_end && final_beat;
			if (beat_end && !write_ff && !aonly_ff)
				rsp_rdata <= sys_data_bus_in;
		end
	end

endmodule

`default_nettype wire

// ### hw/sbm_pkg.sv
// system bus master signalling: shared codes, widths and reset values
// assumes one synchronous clock domain on the master side
`default_nettype none

package sbm_pkg;

	localparam int SBM_ADDR_W = 28;
	localparam int SBM_DATA_W = 32;
	localparam int SBM_LANES  = 4;
	localparam int SBM_CNT_W  = 8;

	// transfer type codes
	localparam logic [1:0] SBM_TT_ADDR_ONLY = 2'h0;
	localparam logic [1:0] SBM_TT_NONSEQ    = 2'h2;
	localparam logic [1:0] SBM_TT_SEQ       = 2'h3;

	// transfer size codes, also used for bus width
	localparam logic [1:0] SBM_SZ_BYTE = 2'h0;
	localparam logic [1:0] SBM_SZ_HALF = 2'h1;
	localparam logic [1:0] SBM_SZ_WORD = 2'h2;
	localparam logic [1:0] SBM_SZ_RSVD = 2'h3;

	// cycle status codes
	localparam logic [2:0] SBM_CT_OPFETCH  = 3'h0;
	localparam logic [2:0] SBM_CT_DATA     = 3'h1;
	localparam logic [2:0] SBM_CT_MISALIGN = 3'h2;
	localparam logic [2:0] SBM_CT_RMW      = 3'h3;
	localparam logic [2:0] SBM_CT_BRANCH   = 3'h4;
	localparam logic [2:0] SBM_CT_RSVD     = 3'h5;
	localparam logic [2:0] SBM_CT_DMA2     = 3'h6;
	localparam logic [2:0] SBM_CT_FLYBY    = 3'h7;

	// sequential status codes; 2..7 are burst lengths 4..128
	localparam logic [2:0] SBM_SEQ_SINGLE    = 3'h0;
	localparam logic [2:0] SBM_SEQ_CONT      = 3'h1;
	localparam logic [2:0] SBM_SEQ_BURST_MIN = 3'h2;
	localparam logic [7:0] SBM_BURST_BASE    = 8'h04;

	// reset values of the driven pins
	localparam logic [27:0] SBM_ADDR_RST  = 28'h0000000;
	localparam logic [31:0] SBM_DATA_RST  = 32'h00000000;
	localparam logic [3:0]  SBM_BEN_N_RST = 4'hF;

	typedef enum logic [2:0] {
		SBM_IDLE = 3'b001,
		SBM_ADDR = 3'b010,
		SBM_DATA = 3'b100
	} sbm_state_type;

endpackage

`default_nettype wire

// ### hw/sbm_lane_if.sv
// carrier between the bus master and its byte lane calculator
// assumes both ends sit in the same clock domain
`default_nettype none

interface sbm_lane_if;
	logic [1:0] addr_lo;
	logic [1:0] beat_size;
	logic [1:0] req_size;
	logic [1:0] width;
	logic [3:0] ben_n;
	logic [2:0] split_beats;

	modport master (
		output addr_lo,
		output beat_size,
		output req_size,
		output width,
		input  ben_n,
		input  split_beats
	);

	modport calc (
		input  addr_lo,
		input  beat_size,
		input  req_size,
		input  width,
		output ben_n,
		output split_beats
	);
endinterface

`default_nettype wire

// ### hw/sbm_lane_calc.sv
// byte lane enables and beat count for one transfer
// assumes size codes are never the reserved value here
`default_nettype none

module sbm_lane_calc (
	// from the master
	sbm_lane_if.calc lane
);

	logic [2:0] lo;
	logic [2:0] nbytes;

	always_comb begin
		nbytes = 3'h1 << lane.beat_size;
		unique case (lane.beat_size)
			sbm_pkg::SBM_SZ_BYTE: lo = {1'b0, lane.addr_lo};
			sbm_pkg::SBM_SZ_HALF: lo = {1'b0, lane.addr_lo[1], 1'b0};
			default:              lo = 3'h0;
		endcase
	end

	// lane n carries data bits 8n+7..8n
	for (genvar i = 0; i < sbm_pkg::SBM_LANES; i++) begin : g_lane
		assign lane.ben_n[i] = !((3'(i) >= lo) && (3'(i) < lo + nbytes));
	end

	// a transfer wider than the bus becomes 2 or 4 narrower beats
	always_comb begin
		if (lane.req_size > lane.width)
			lane.split_beats = 3'h1 << (lane.req_size - lane.width);
		else
			lane.split_beats = 3'h1;
	end

endmodule

`default_nettype wire

// ### verification/sbm_slave_model.sv
// bus slave model: wait and last responses, read data
// assumes it watches the master's start strobe and beat address
`default_nettype none

module sbm_slave_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// from the master
	input  wire logic        start_n,
	input  wire logic [27:0] addr,
	// scenario controls
	input  wire logic [1:0]  waits,
	input  wire logic        last_cmd,
	// responses
	output logic             wait_response,
	output logic             last_response,
	output logic [31:0]      rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       dphase_ff;
	logic [1:0] cnt_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dphase_ff <= 1'h0;
			cnt_ff    <= 2'h0;
		end else if (!start_n) begin
			dphase_ff <= 1'h1;
			cnt_ff    <= waits;
		end else if (cnt_ff != 2'h0) begin
			cnt_ff <= cnt_ff - 2'h1;
		end else begin
			dphase_ff <= 1'h0;
		end
	end

	assign wait_response = dphase_ff && cnt_ff != 2'h0;
	// last only on the ending cycle, so it is never lost in a wait
	assign last_response = dphase_ff && cnt_ff == 2'h0 && last_cmd;
	// off the data phase the lines show the inverse, never stale data
	assign rdata = dphase_ff ? {4'hA, addr} : ~{4'hA, addr};
endmodule

`default_nettype wire

// ### verification/sbm_master_asserts.sv
// checker: timing relations between the master's bus pins
// assumes one clock domain; bound onto every sbm_master
`default_nettype none

module sbm_master_asserts (
	// clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// ownership and mode
	input wire logic       ownership_request_in,
	input wire logic       ownership_grant_out,
	input wire logic       ownership_lock_out,
	input wire logic       misalign_enable_mode,
	// bus qualifiers
	input wire logic       transfer_start_n_out,
	input wire logic [1:0] transfer_type_out,
	input wire logic [1:0] transfer_size_out,
	input wire logic       write_not_read_out,
	input wire logic [2:0] cycle_status_out,
	input wire logic [2:0] sequential_status_out,
	input wire logic       sys_data_bus_oe_n,
	// responses
	input wire logic       wait_response,
	input wire logic       last_response,
	input wire logic       rsp_valid,
	input wire logic       rsp_last
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	start_pulse_a: assert property ($fell(transfer_start_n_out) |=>
		transfer_start_n_out) else $error("start strobe too long");
	type_code_a: assert property (!transfer_start_n_out |->
		transfer_type_out != 2'h1) else $error("reserved type");
	size_code_a: assert property (!transfer_start_n_out |->
		transfer_size_out != sbm_pkg::SBM_SZ_RSVD) else $error("reserved size");
	misalign_gate_a: assert property (!transfer_start_n_out &&
		!misalign_enable_mode |-> cycle_status_out != 3'h2)
		else $error("misalign code while disabled");
	cycle_rsvd_a: assert property (!transfer_start_n_out |->
		cycle_status_out != 3'h5) else $error("reserved cycle status");
	write_dir_a: assert property (!sys_data_bus_oe_n |->
		write_not_read_out) else $error("data driven on a read");
	grant_cause_a: assert property ($rose(ownership_grant_out) |->
		$past(ownership_request_in) && !$past(ownership_lock_out))
		else $error("grant without request or under lock");
	grant_drop_a: assert property (ownership_grant_out &&
		!ownership_request_in |=> !ownership_grant_out)
		else $error("grant held after request dropped");
	wait_stretch_a: assert property (!transfer_start_n_out ##1
		wait_response |=> transfer_start_n_out && !rsp_valid)
		else $error("wait did not stretch the beat");
	beat_done_a: assert property ((!transfer_start_n_out &&
		transfer_type_out != 2'h0) ##1 !wait_response |=> rsp_valid)
		else $error("beat did not end");
	seq_final_a: assert property (rsp_last |->
		sequential_status_out == 3'h0) else $error("final beat not single");
	decode_cycle_a: assert property (rsp_valid && $past(last_response) &&
		!transfer_start_n_out && transfer_type_out != 2'h0 |->
		transfer_type_out == 2'h2) else $error("no decode cycle after last");

	cover property (!transfer_start_n_out && sequential_status_out == 3'h7);
	cover property ($rose(ownership_grant_out));
	cover property (rsp_valid && $past(last_response));
endmodule

bind sbm_master sbm_master_asserts u_sbm_master_asserts (.clk, .resetn,
	.ownership_request_in, .ownership_grant_out, .ownership_lock_out,
	.misalign_enable_mode, .transfer_start_n_out, .transfer_type_out,
	.transfer_size_out, .write_not_read_out, .cycle_status_out,
	.sequential_status_out, .sys_data_bus_oe_n, .wait_response,
	.last_response, .rsp_valid, .rsp_last);

`default_nettype wire

// ### verification/test_system_bus_master_signalling.sv
// bench: table of transfers, bursts of every length, ownership
// assumes the slave model answers every beat of the master
`default_nettype none

module test_system_bus_master_signalling;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic [27:0] a;
		logic        w;
		logic [1:0]  sz, bw;
		logic [2:0]  ct, sq;
		logic        pe, ma;
		logic [3:0]  ben;
		int          n;
		logic [2:0]  s0, c0;
	} sbm_row_type;
	localparam logic [31:0] WD = 32'hA5C30F96;
	logic clk, resetn, ownership_request_in, ownership_grant_out;
	logic misalign_enable_mode, req_valid, req_ready, req_write;
	logic req_addr_only, req_lock, req_periph, rsp_valid, rsp_last;
	logic transfer_start_n_out, write_not_read_out, ownership_lock_out;
	logic qualifier_oe_n, sys_data_bus_oe_n, wait_response, last_response;
	logic last_cmd;
	logic [1:0] bus_width_sel, req_size, transfer_type_out;
	logic [1:0] transfer_size_out, waits;
	logic [2:0] req_ctype, req_seq, cycle_status_out, sequential_status_out;
	logic [3:0] byte_lane_enable_n_out;
	logic [27:0] req_addr, sys_address_bus_out;
	logic [31:0] req_wdata, rsp_rdata, sys_data_bus_in, sys_data_bus_out;
	int fails, cmp_count, cyc;
	sbm_row_type r;
	sbm_row_type rows[7] = '{
		'{28'h1, 1'h0, 2'h0, 2'h2, 3'h1, 3'h0, 1'h0, 1'h0, 4'hD, 1, 3'h0, 3'h1},
		'{28'h2, 1'h1, 2'h1, 2'h2, 3'h1, 3'h0, 1'h0, 1'h0, 4'h3, 1, 3'h0, 3'h1},
		'{28'h10, 1'h0, 2'h2, 2'h2, 3'h0, 3'h0, 1'h0, 1'h0, 4'h0, 1, 3'h0, 3'h0},
		'{28'h20, 1'h0, 2'h2, 2'h0, 3'h3, 3'h0, 1'h0, 1'h0, 4'hE, 4, 3'h1, 3'h3},
		'{28'h30, 1'h1, 2'h2, 2'h1, 3'h4, 3'h0, 1'h0, 1'h0, 4'hC, 2, 3'h1, 3'h4},
		'{28'h40, 1'h0, 2'h2, 2'h2, 3'h6, 3'h0, 1'h1, 1'h0, 4'hC, 2, 3'h1, 3'h6},
		'{28'h50, 1'h0, 2'h2, 2'h2, 3'h2, 3'h0, 1'h0, 1'h0, 4'h0, 1, 3'h0, 3'h1}};

	sbm_master u_sbm_master (.clk, .resetn, .ownership_request_in,
		.ownership_grant_out, .misalign_enable_mode, .bus_width_sel,
		.req_valid, .req_ready, .req_addr, .req_write, .req_size, .req_ctype,
		.req_seq, .req_addr_only, .req_lock, .req_periph, .req_wdata,
		.rsp_valid, .rsp_last, .rsp_rdata, .sys_address_bus_out,
		.transfer_type_out, .transfer_start_n_out, .byte_lane_enable_n_out,
		.transfer_size_out, .write_not_read_out, .ownership_lock_out,
		.cycle_status_out, .sequential_status_out, .qualifier_oe_n,
		.sys_data_bus_in, .sys_data_bus_out, .sys_data_bus_oe_n,
		.wait_response, .last_response);
	sbm_slave_model u_sbm_slave_model (.clk, .resetn,
		.start_n(transfer_start_n_out), .addr(sys_address_bus_out), .waits,
		.last_cmd, .wait_response, .last_response, .rdata(sys_data_bus_in));

	always #2.5 clk = ~clk;

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic run(input sbm_row_type t, input logic [1:0] wt,
		input logic lc);
		int beats;
		int k;
		beats = 0;
		k = 0;
		{misalign_enable_mode, bus_width_sel, req_addr} = {t.ma, t.bw, t.a};
		{req_write, req_size, req_ctype, req_seq} = {t.w, t.sz, t.ct, t.sq};
		{req_periph, waits, last_cmd, req_valid} = {t.pe, wt, lc, 1'h1};
		while (req_ready !== 1'h1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		req_valid = 1'h0;
		while (rsp_last !== 1'h1) begin
			if (transfer_start_n_out === 1'h0 && k == 0) begin
				chk(byte_lane_enable_n_out, t.ben);
				chk(sequential_status_out, t.s0);
				chk(cycle_status_out, t.c0);
				chk(transfer_type_out, {~req_addr_only, 1'h0});
				chk(sys_address_bus_out, t.a);
				chk(write_not_read_out, t.w);
				chk(sys_data_bus_oe_n, !(t.w && !req_addr_only));
				if (t.n == 1)
					chk(transfer_size_out, t.sz);
				if (t.n == 1 && t.w)
					chk(sys_data_bus_out, WD);
			end else if (transfer_start_n_out === 1'h0 && k == 1) begin
				chk(transfer_type_out, lc ? 2'h2 : 2'h3);
			end
			if (transfer_start_n_out === 1'h0)
				k++;
			if (rsp_valid === 1'h1)
				beats++;
			@(posedge clk);
			#1;
		end
		chk(beats + 1, t.n);
		if (t.n == 1 && !t.w && !req_addr_only)
			chk(rsp_rdata, {4'hA, t.a});
	endtask

	initial begin
		{clk, resetn, ownership_request_in, misalign_enable_mode} = 4'h0;
		{req_valid, req_write, req_addr_only, req_lock, req_periph} = 5'h0;
		{bus_width_sel, req_size, req_ctype, req_seq} = 10'h0;
		{waits, last_cmd, req_addr, req_wdata} = {3'h0, 28'h0, WD};
		repeat (2) @(posedge clk);
		#1;
		chk(byte_lane_enable_n_out, 4'hF);
		chk(transfer_start_n_out, 1'h1);
		chk(ownership_grant_out, 1'h0);
		chk(qualifier_oe_n, 1'h0);
		chk(sys_data_bus_oe_n, 1'h1);
		chk(ownership_lock_out, 1'h0);
		resetn = 1'h1;
		foreach (rows[i])
			run(rows[i], 2'h0, 1'h0);
		for (int s = 2; s < 8; s++) begin
			r = '{28'h100, 1'h0, 2'h2, 2'h2, 3'(s), 3'(s), 1'h0, 1'h1, 4'h0,
				4 << (s - 2), 3'(s), (s == 5) ? 3'h1 : 3'(s)};
			run(r, (s == 3) ? 2'h2 : 2'h0, s == 2);
		end
		req_addr_only = 1'h1;
		run(rows[2], 2'h0, 1'h0);
		req_addr_only = 1'h0;
		req_lock = 1'h1;
		run(rows[2], 2'h0, 1'h0);
		chk(ownership_lock_out, 1'h1);
		ownership_request_in = 1'h1;
		repeat (3) @(posedge clk);
		#1;
		chk(ownership_grant_out, 1'h0);
		req_lock = 1'h0;
		run(rows[2], 2'h0, 1'h0);
		chk(ownership_lock_out, 1'h0);
		repeat (3) @(posedge clk);
		#1;
		chk(ownership_grant_out, 1'h1);
		chk(qualifier_oe_n, 1'h1);
		chk(req_ready, 1'h0);
		ownership_request_in = 1'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(ownership_grant_out, 1'h0);
		chk(qualifier_oe_n, 1'h0);
		// reset in the middle of a write beat, then a fresh read
		req_write = 1'h1;
		req_valid = 1'h1;
		@(posedge clk);
		#1;
		chk(sys_data_bus_oe_n, 1'h0);
		resetn = 1'h0;
		req_valid = 1'h0;
		#1;
		chk(transfer_start_n_out, 1'h1);
		chk(sys_data_bus_oe_n, 1'h1);
		chk(byte_lane_enable_n_out, 4'hF);
		@(posedge clk);
		#1;
		resetn = 1'h1;
		run(rows[0], 2'h0, 1'h0);
		final_report();
	end
endmodule

`default_nettype wire
